// File: rtl/video_capture_line_channel.v
/*
 * Video capture channel: samples an external pixel port, packs luma, Cb and
 * Cr into doubleword FIFOs, raises DMA requests and completion flags.
 * Assumes an AHB-Lite master on hclk and a pixel source on its own clock,
 * with separate line, field-start and field-id pins.
 */
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ns
`include "vcap_defs.vh"
module video_capture_line_channel #(
    parameter FIFO_AW = 5
) (
    input  wire        hclk,                    // bus clock
    input  wire        hresetn,                 // async reset, low
    input  wire        hsel,                    // slave select
    input  wire [31:0] haddr,                   // address
    input  wire [1:0]  htrans,                  // transfer type
    input  wire        hwrite,                  // write
    input  wire [2:0]  hsize,                   // size, word only
    input  wire [31:0] hwdata,                  // write data
    input  wire        hready,                  // bus ready
    output reg  [31:0] hrdata,                  // read data
    output reg         hreadyout,               // slave ready
    output reg         hresp,                   // always OKAY
    input  wire        vid_clk,                 // pixel clock
    input  wire        vid_line,                // line start level
    input  wire        vid_vsync,               // field or packet start
    input  wire        vid_field,               // field id, 1 = field two
    input  wire [9:0]  vid_luma,                // luma or interleaved bus
    input  wire [9:0]  vid_chroma,              // chroma bus
    output reg         luma_dma_request,        // luma DMA pulse
    output reg         blue_chroma_dma_request, // Cb DMA pulse
    output reg         red_chroma_dma_request,  // Cr DMA pulse
    output reg         port_irq                 // interrupt
);
    localparam DEPTH = 1 << FIFO_AW;
    localparam S_IDLE = 2'd0;
    localparam S_WAIT = 2'd1;
    localparam S_ACT  = 2'd2;
    localparam S_HALT = 2'd3;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    reg  [2:0]  vclk_ff;
    reg  [2:0]  line_ff;
    reg  [2:0]  vs_ff;
    reg  [1:0]  fld_ff;
    reg  [9:0]  luma_s1_ff;
    reg  [9:0]  luma_s2_ff;
    reg  [9:0]  chr_s1_ff;
    reg  [9:0]  chr_s2_ff;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            vclk_ff    <= 3'h0;
            line_ff    <= 3'h0;
            vs_ff      <= 3'h0;
            fld_ff     <= 2'h0;
            luma_s1_ff <= 10'h000;
            luma_s2_ff <= 10'h000;
            chr_s1_ff  <= 10'h000;
            chr_s2_ff  <= 10'h000;
        end
        else
        begin
            vclk_ff    <= {vclk_ff[1:0], vid_clk};
            line_ff    <= {line_ff[1:0], vid_line};
            vs_ff      <= {vs_ff[1:0], vid_vsync};
            fld_ff     <= {fld_ff[0], vid_field};
            luma_s1_ff <= vid_luma;
            luma_s2_ff <= luma_s1_ff;
            chr_s1_ff  <= vid_chroma;
            chr_s2_ff  <= chr_s1_ff;
        end
    end

    wire pix_edge  = vclk_ff[1] & ~vclk_ff[2];
    wire line_edge = line_ff[1] & ~line_ff[2];
    wire vs_edge   = vs_ff[1] & ~vs_ff[2];
    wire fld       = fld_ff[1];

    // ------------------------------------------------------------------
    // Registers and decode
    // ------------------------------------------------------------------
    reg  [`CTL_W-1:0] ctrl_ff;
    reg  [1:0]  irq_en_ff;
    reg  [11:0] hfirst_ff;
    reg  [11:0] vfirst_ff;
    reg  [11:0] hstop_ff;
    reg  [11:0] vstop_ff;
    reg  [11:0] thr_ff;
    reg  [4:0]  flags_ff;
    reg  [1:0]  state_ff;
    reg  [1:0]  nxt_state;
    reg  [2:0]  halt_sel_ff;
    reg         live_ff;
    reg         blocked_ff;
    reg  [11:0] hpos_ff;
    reg  [11:0] vpos_ff;
    reg  [1:0]  phase_ff;
    reg  [23:0] dcount_ff;
    reg  [11:0] pix_cnt_ff;

    wire        cap_en  = ctrl_ff[`CTL_EN];
    wire [2:0]  fmt     = ctrl_ff[`CTL_FMT];
    wire        pkt     = fmt[1];
    wire        bt656   = ~fmt[2] & ~fmt[1];
    wire        f1sel   = ctrl_ff[`CTL_F1];
    wire        f2sel   = ctrl_ff[`CTL_F2];
    wire [1:0]  pmode   = ctrl_ff[`CTL_PACK];
    wire        blk     = ctrl_ff[`CTL_BLK];

    // ------------------------------------------------------------------
    // Sample routing and position counters
    // ------------------------------------------------------------------
    // Interleaved bus carries Cb Y Cr Y; separate buses alternate Cb/Cr
    wire is_y  = pix_edge & (~bt656 | phase_ff[0]);
    wire is_cb = pix_edge & ~pkt & ~phase_ff[0] & (~bt656 | ~phase_ff[1]);
    wire is_cr = pix_edge & ~pkt & (bt656 ? (phase_ff == 2'd2) : phase_ff[0]);
    wire [9:0] chr_smp = bt656 ? luma_s2_ff : chr_s2_ff;

    // Counters run regardless of blocking so the window stays in step
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hpos_ff  <= 12'h000;
            vpos_ff  <= 12'h000;
            phase_ff <= 2'h0;
        end
        else
        begin
            if (line_edge)
            begin
                hpos_ff  <= 12'h000;
                phase_ff <= 2'h0;
            end
            else
            begin
                if (pix_edge)
                    phase_ff <= phase_ff + 2'h1;
                if (is_y)
                    hpos_ff <= hpos_ff + 12'h001;
            end
            if (vs_edge)
                vpos_ff <= 12'hFFF;
            else if (line_edge)
                vpos_ff <= vpos_ff + 12'h001;
        end
    end

    wire in_win = (hpos_ff >= hfirst_ff) && (hpos_ff <= hstop_ff) &&
                  (vpos_ff >= vfirst_ff) && (vpos_ff <= vstop_ff);
    wire storing  = live_ff & ~blocked_ff & (state_ff == S_ACT);
    wire line_end = storing & ~pkt & is_y & in_win & (hpos_ff == hstop_ff);
    wire [23:0] pkt_size = {vstop_ff, hstop_ff};
    wire pkt_end  = storing & pkt & is_y & ((dcount_ff + 24'h1) == pkt_size);
    wire vid_done = line_end & (vpos_ff == vstop_ff);
    wire done_evt = vid_done | pkt_end;

    wire [2:0]  ch_valid;
    wire [29:0] ch_data;
    wire [2:0]  ch_flush;
    wire [2:0]  ch_pop;
    wire [2:0]  ch_ovr;
    wire [95:0] ch_word;

    assign ch_valid[0] = storing & is_y & (pkt | in_win);
    assign ch_valid[1] = storing & is_cb & in_win;
    assign ch_valid[2] = storing & is_cr & in_win;
    assign ch_data     = {chr_smp, chr_smp, luma_s2_ff};
    assign ch_flush    = {3{line_end | pkt_end}};

    // ------------------------------------------------------------------
    // Packers and doubleword FIFOs, one per component
    // ------------------------------------------------------------------
    function [5:0] slot_off;
        input [1:0] pm;
        input [2:0] s;
        begin
            if (pm == `PACK_8)
                slot_off = {s, 3'b000};
            else if (pm == `PACK_10)
                slot_off = {s[1:0], 4'b0000};
            else
                case (s)
                    3'd0:    slot_off = 6'd0;
                    3'd1:    slot_off = 6'd10;
                    3'd2:    slot_off = 6'd20;
                    3'd3:    slot_off = 6'd32;
                    3'd4:    slot_off = 6'd42;
                    default: slot_off = 6'd52;
                endcase
        end
    endfunction

    genvar c;
    generate
        for (c = 0; c < 3; c = c + 1)
        begin : g_ch
            reg  [63:0]      mem [0:DEPTH-1];
            reg  [63:0]      pack_ff;
            reg  [2:0]       slot_ff;
            reg  [FIFO_AW:0] wp_ff;
            reg  [FIFO_AW:0] rp_ff;
            reg              half_ff;
            wire [9:0]  d    = ch_data[c*10 +: 10];
            wire [9:0]  smp  = (pmode == `PACK_8) ? {2'b00, d[9:2]} : d;
            wire [63:0] ins  = {54'h0, smp} << slot_off(pmode, slot_ff);
            wire [2:0]  last = (pmode == `PACK_8) ? 3'd7 : ((pmode == `PACK_10) ? 3'd3 : 3'd5);
            wire [63:0] wr_word = pack_ff | (ch_valid[c] ? ins : 64'h0);
            // Early write at line end leaves unused lanes as zero padding
            wire do_wr = (ch_valid[c] & (slot_ff == last)) |
                         (ch_flush[c] & (ch_valid[c] | (slot_ff != 3'd0)));
            wire empty = (wp_ff == rp_ff);
            wire full  = (wp_ff[FIFO_AW] != rp_ff[FIFO_AW]) &&
                         (wp_ff[FIFO_AW-1:0] == rp_ff[FIFO_AW-1:0]);
            wire [63:0] head = mem[rp_ff[FIFO_AW-1:0]];

            assign ch_ovr[c] = do_wr & full;
            assign ch_word[c*32 +: 32] = empty ? 32'h0 : (half_ff ? head[63:32] : head[31:0]);

            always @(posedge hclk)
            begin
                if (do_wr && !full && !blocked_ff)
                    mem[wp_ff[FIFO_AW-1:0]] <= wr_word;
            end

            always @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    pack_ff <= 64'h0;
                    slot_ff <= 3'd0;
                    wp_ff   <= {(FIFO_AW+1){1'b0}};
                    rp_ff   <= {(FIFO_AW+1){1'b0}};
                    half_ff <= 1'b0;
                end
                else if (blocked_ff)
                begin
                    pack_ff <= 64'h0;
                    slot_ff <= 3'd0;
                    wp_ff   <= {(FIFO_AW+1){1'b0}};
                    rp_ff   <= {(FIFO_AW+1){1'b0}};
                    half_ff <= 1'b0;
                end
                else
                begin
                    if (do_wr)
                    begin
                        pack_ff <= 64'h0;
                        slot_ff <= 3'd0;
                    end
                    else if (ch_valid[c])
                    begin
                        pack_ff <= wr_word;
                        slot_ff <= slot_ff + 3'd1;
                    end
                    if (do_wr && !full)
                        wp_ff <= wp_ff + 1'b1;
                    if (ch_pop[c] && !empty)
                    begin
                        half_ff <= ~half_ff;
                        if (half_ff)
                            rp_ff <= rp_ff + 1'b1;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Capture sequencing and flags
    // ------------------------------------------------------------------
    wire sel_field  = pkt | (fld ? f2sel : f1sel);
    wire frame_strt = vs_edge & (pkt | ~fld);
    wire both_sel   = f1sel & f2sel;
    wire [4:0] set_vec;
    assign set_vec[`ST_F1]   = vid_done & ~fld;
    assign set_vec[`ST_F2]   = vid_done & fld;
    assign set_vec[`ST_FRM]  = pkt_end | (vid_done & fld & both_sel);
    assign set_vec[`ST_OVR]  = |ch_ovr;
    assign set_vec[`ST_DONE] = |set_vec[2:0];
    // Flag that governs restart for this completion
    wire [2:0] evt_sel = (pkt | (fld & both_sel)) ? 3'b100 : (fld ? 3'b010 : 3'b001);
    wire evt_frame = pkt | (fld & both_sel);
    wire halt_now  = ctrl_ff[`CTL_SINGLE] ? evt_frame :
                     (~ctrl_ff[`CTL_CONT] & |(flags_ff[2:0] & evt_sel));

    always @*
    begin
        nxt_state = state_ff;
        case (state_ff)
            S_IDLE:  if (cap_en) nxt_state = S_WAIT;
            S_WAIT:  if (frame_strt) nxt_state = S_ACT;
            S_ACT:   if (done_evt && halt_now) nxt_state = S_HALT;
            S_HALT:  if (~|(flags_ff[2:0] & halt_sel_ff)) nxt_state = S_ACT;
            default: nxt_state = S_IDLE;
        endcase
        if (!cap_en)
            nxt_state = S_IDLE;
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_ff    <= S_IDLE;
            halt_sel_ff <= 3'b000;
            live_ff     <= 1'b0;
            blocked_ff  <= 1'b0;
            dcount_ff   <= 24'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            if (state_ff == S_ACT && done_evt && halt_now)
                halt_sel_ff <= evt_sel;
            // Storage opens only at the start of a selected field
            if (vs_edge)
                live_ff <= sel_field & ((state_ff == S_ACT) || (state_ff == S_WAIT && frame_strt));
            else if (done_evt)
                live_ff <= 1'b0;
            if (blk)
                blocked_ff <= 1'b1;
            else if (vs_edge)
                blocked_ff <= 1'b0;
            if (vs_edge)
                dcount_ff <= 24'h0;
            else if (ch_valid[0])
                dcount_ff <= dcount_ff + 24'h1;
        end
    end

    // ------------------------------------------------------------------
    // DMA requests
    // ------------------------------------------------------------------
    wire thr_hit = ch_valid[0] && (thr_ff != 12'h000) && ((pix_cnt_ff + 12'h001) == thr_ff);

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pix_cnt_ff              <= 12'h000;
            luma_dma_request        <= 1'b0;
            blue_chroma_dma_request <= 1'b0;
            red_chroma_dma_request  <= 1'b0;
        end
        else
        begin
            // Blocked field counts nothing, so no request escapes
            if (blocked_ff || thr_hit)
                pix_cnt_ff <= 12'h000;
            else if (ch_valid[0])
                pix_cnt_ff <= pix_cnt_ff + 12'h001;
            luma_dma_request        <= thr_hit;
            blue_chroma_dma_request <= thr_hit & ~pkt;
            red_chroma_dma_request  <= thr_hit & ~pkt;
        end
    end

    // ------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------
    reg         wr_pend_ff;
    reg  [7:0]  wr_addr_ff;
    reg         rd_pend_ff;
    reg  [7:0]  rd_addr_ff;
    reg  [31:0] rd_mux;
    wire        accept  = hsel & htrans[1] & hready;
    wire        rd_take = rd_pend_ff & ~hreadyout;
    wire        wr_go   = wr_pend_ff;

    assign ch_pop[0] = rd_take & (rd_addr_ff == `OFS_LUMA);
    assign ch_pop[1] = rd_take & (rd_addr_ff == `OFS_CB);
    assign ch_pop[2] = rd_take & (rd_addr_ff == `OFS_CR);

    always @*
    begin
        case (rd_addr_ff)
            `OFS_CTRL:  rd_mux = {21'h0, ctrl_ff};
            `OFS_STAT:  rd_mux = {26'h0, state_ff == S_ACT, flags_ff};
            `OFS_IRQEN: rd_mux = {27'h0, irq_en_ff, 3'b000};
            `OFS_FIRST: rd_mux = {4'h0, vfirst_ff, 4'h0, hfirst_ff};
            `OFS_STOP:  rd_mux = {4'h0, vstop_ff, 4'h0, hstop_ff};
            `OFS_THR:   rd_mux = {20'h0, thr_ff};
            `OFS_POS:   rd_mux = {4'h0, vpos_ff, 4'h0, hpos_ff};
            `OFS_COUNT: rd_mux = {8'h0, dcount_ff};
            `OFS_LUMA:  rd_mux = ch_word[31:0];
            `OFS_CB:    rd_mux = ch_word[63:32];
            `OFS_CR:    rd_mux = ch_word[95:64];
            default:    rd_mux = 32'h0;
        endcase
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata     <= 32'h0;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            rd_pend_ff <= 1'b0;
            rd_addr_ff <= 8'h00;
        end
        else
        begin
            hresp      <= 1'b0;
            wr_pend_ff <= accept & hwrite;
            if (accept)
            begin
                wr_addr_ff <= {haddr[7:2], 2'b00};
                rd_addr_ff <= {haddr[7:2], 2'b00};
            end
            // One wait state lets a read see a write just finished
            if (accept && !hwrite)
            begin
                rd_pend_ff <= 1'b1;
                hreadyout  <= 1'b0;
            end
            else if (rd_take)
            begin
                rd_pend_ff <= 1'b0;
                hreadyout  <= 1'b1;
                hrdata     <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------------
    // Register writes, flags and interrupt
    // ------------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_ff   <= `CTRL_RST;
            irq_en_ff <= 2'b00;
            hfirst_ff <= `POS_RST;
            vfirst_ff <= `POS_RST;
            hstop_ff  <= `POS_RST;
            vstop_ff  <= `POS_RST;
            thr_ff    <= `THR_RST;
            flags_ff  <= 5'h00;
            port_irq  <= 1'b0;
        end
        else
        begin
            if (wr_go)
                case (wr_addr_ff)
                    `OFS_CTRL:  ctrl_ff   <= hwdata[`CTL_W-1:0];
                    `OFS_IRQEN: irq_en_ff <= hwdata[4:3];
                    `OFS_FIRST:
                    begin
                        hfirst_ff <= hwdata[11:0];
                        vfirst_ff <= hwdata[27:16];
                    end
                    `OFS_STOP:
                    begin
                        hstop_ff <= hwdata[11:0];
                        vstop_ff <= hwdata[27:16];
                    end
                    `OFS_THR:   thr_ff <= hwdata[11:0];
                    default:    ;
                endcase
            // A flag set in the clearing cycle survives the clear
            flags_ff <= (flags_ff & ~((wr_go && wr_addr_ff == `OFS_STAT) ? hwdata[4:0] : 5'h00))
                        | set_vec;
            port_irq <= |(flags_ff[4:3] & irq_en_ff);
        end
    end
endmodule

// File: pkg/vcap_defs.vh
/*
 * Register offsets, field positions, reset values and encodings of the
 * video capture channel. Assumes byte addresses on a 32-bit AHB-Lite bus.
 */
`ifndef VCAP_DEFS_VH
`define VCAP_DEFS_VH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_CTRL   8'h00
`define OFS_STAT   8'h04
`define OFS_IRQEN  8'h08
`define OFS_FIRST  8'h0C
`define OFS_STOP   8'h10
`define OFS_THR    8'h14
`define OFS_POS    8'h18
`define OFS_COUNT  8'h1C
`define OFS_LUMA   8'h20
`define OFS_CB     8'h24
`define OFS_CR     8'h28
// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define CTL_EN     0
`define CTL_FMT    3:1
`define CTL_CONT   4
`define CTL_SINGLE 5
`define CTL_F1     6
`define CTL_F2     7
`define CTL_PACK   9:8
`define CTL_BLK    10
`define CTL_W      11
// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define ST_F1      0
`define ST_F2      1
`define ST_FRM     2
`define ST_OVR     3
`define ST_DONE    4
`define ST_RUN     5
// ----------------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------------
`define CTRL_RST   11'h000
`define POS_RST    12'h000
`define THR_RST    12'h000
`define PACK_8     2'h0
`define PACK_10    2'h1
`define PACK_DENSE 2'h2
`endif

// File: testbench/vcap_checker_properties.sv
/* Checker of bus wait states and DMA request pulses at the channel ports.
   Assumes a bind onto the channel top; sees its ports only. */
`timescale 1ns/1ns
module vcap_checker (
    input wire        hclk, // clock
    input wire        hresetn, // reset
    input wire        hsel, // select
    input wire [31:0] haddr, // address
    input wire [1:0]  htrans, // transfer
    input wire        hwrite, // write
    input wire [31:0] hwdata, // data
    input wire        hreadyout, // ready
    input wire        luma_dma_request, // Y request
    input wire        blue_chroma_dma_request, // Cb request
    input wire        red_chroma_dma_request // Cr request
);
reg  blk_ff;
reg  wctl_ff;
wire req_acc = hsel & htrans[1] & hreadyout;
default clocking @(posedge hclk); endclocking
default disable iff (!hresetn);
// Copy of the block bit, landing with the register; a request already launched still shows for two cycles
always @(posedge hclk or negedge hresetn)
    if (!hresetn)
        {wctl_ff, blk_ff} <= 2'b00;
    else
        {wctl_ff, blk_ff} <= {req_acc & hwrite & (haddr[7:0] == 8'h00), wctl_ff ? hwdata[10] : blk_ff};
AST_Y_GAP: assert property (luma_dma_request |=> !luma_dma_request [*3]) else $error("Y requests too close");
AST_CB_PULSE: assert property (blue_chroma_dma_request |=> !blue_chroma_dma_request) else $error("Cb pulse long");
AST_C_WITH_Y: assert property (blue_chroma_dma_request |-> luma_dma_request) else $error("Cb without Y");
AST_CB_CR: assert property (blue_chroma_dma_request == red_chroma_dma_request) else $error("Cb and Cr differ");
AST_BLOCKED: assert property (blk_ff && $past(blk_ff) && $past(blk_ff, 2)
    |-> !(luma_dma_request | blue_chroma_dma_request | red_chroma_dma_request))
    else $error("request while blocked");
AST_READ_WAIT: assert property (req_acc && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
AST_WRITE_ZERO: assert property (req_acc && hwrite |=> hreadyout) else $error("write waited");
AST_RESET_QUIET: assert property ($rose(hresetn) |-> !luma_dma_request) else $error("request after reset");
endmodule

// File: testbench/video_source_model.sv
/* Video source: one field of lines on a 64 ns pixel clock.
   Assumes the bench calls send_field off the hclk edges. */
`timescale 1ns/1ns
module video_source_model (
    output logic       vid_clk, // pixel clock
    output logic       vid_line, // line start
    output logic       vid_vsync, // field start
    output logic       vid_field, // field id
    output logic [9:0] vid_luma, // luma bus
    output logic [9:0] vid_chroma // chroma bus
);
// Clock stands still between fields so no stray pixel is seen
initial {vid_clk, vid_line, vid_vsync, vid_field, vid_luma, vid_chroma} = '0;
task automatic send_field(input logic f, input int nl, input int np);
    vid_field = f;
    vid_vsync = 1'b1;
    #64 vid_vsync = 1'b0;
    for (int l = 0; l < nl; l++)
    begin
        #64 vid_line = 1'b1;
        #64 vid_line = 1'b0;
        for (int p = 0; p < np; p++)
        begin
            vid_luma = {8'(l * 16 + p), 2'b00};
            vid_chroma = ~vid_luma;
            #32 vid_clk = 1'b1;
            #32 vid_clk = 1'b0;
        end
    end
    // Data is stale after the field: show its inverse
    vid_luma = ~vid_luma;
    vid_chroma = ~vid_chroma;
endtask
endmodule

// File: testbench/test_video_capture_line_channel.sv
/* Bench: AHB-Lite master, video source, self checks.
   Assumes the model and checker compile before it. */
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; $display("BAD %0t got %h", $time, a); end end
module test_video_capture_line_channel;
logic        hclk, hresetn, hsel, hwrite;
logic [1:0]  htrans;
logic [2:0]  hsize;
logic [31:0] haddr, hwdata, hrdata, r, e;
logic        hreadyout, hresp, port_irq, ry, rb, rr;
wire         vid_clk, vid_line, vid_vsync, vid_field;
wire  [9:0]  vid_luma, vid_chroma;
int          n_errors, tests_run, n_req, n_cb, cyc;
logic [39:0] cfg [5] = '{{8'h0C, 32'h0}, {8'h10, 32'h10005}, {8'h14, 32'h4}, {8'h08, 32'h10}, {8'h00, 32'h49}};
video_capture_line_channel #(.FIFO_AW(5)) video_capture_line_channel_inst (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .vid_clk,
    .vid_line, .vid_vsync, .vid_field, .vid_luma, .vid_chroma, .luma_dma_request(ry),
    .blue_chroma_dma_request(rb), .red_chroma_dma_request(rr), .port_irq);
video_source_model video_source_model_inst (.vid_clk, .vid_line, .vid_vsync, .vid_field, .vid_luma, .vid_chroma);
always #4 hclk = ~hclk;
always @(posedge hclk)
begin
    n_req <= n_req + ry;
    n_cb <= n_cb + rb;
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
        n_errors++;
        print_verdict();
    end
end
task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    haddr <= {24'h000000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
endtask
function automatic logic [31:0] luma_exp(input int l, input int w);
    for (int k = 0; k < 4; k++)
        luma_exp[8 * k +: 8] = 8'(l * 16 + w * 4 + k);
endfunction
task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
endtask
initial
begin
    {hclk, hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    void'($urandom(32'h9882));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(0, 8'h00, 0); `CHK(r, 32'h0) `CHK(hresp, 1'b0)
    bus(0, 8'h3C, 0); `CHK(r, 32'h0)
    e = {20'h0, 12'($urandom) & 12'hFFE};
    bus(1, 8'h14, e); bus(0, 8'h14, 0); `CHK(r, e)
    $display("register test done");
    foreach (cfg[i]) bus(1, cfg[i][39:32], cfg[i][31:0]);
    #2 video_source_model_inst.send_field(1'b0, 2, 6);
    repeat (20) @(posedge hclk);
    `CHK(n_req, 3)
    `CHK(n_cb, 3)
    `CHK(port_irq, 1'b1)
    bus(0, 8'h04, 0); `CHK(r[0], 1'b1)
    for (int l = 0; l < 2; l++)
    begin
        bus(0, 8'h20, 0); `CHK(r, luma_exp(l, 0))
        e = luma_exp(l, 1);
        bus(0, 8'h20, 0); `CHK(r[15:0], e[15:0])
    end
    bus(0, 8'h24, 0); `CHK(r[23:0], {~8'd4, ~8'd2, ~8'd0})
    $display("line capture test done");
    bus(1, 8'h04, 32'h1F); bus(1, 8'h00, 32'h449);
    #2 video_source_model_inst.send_field(1'b0, 2, 6);
    repeat (20) @(posedge hclk);
    `CHK(n_req, 3)
    `CHK(n_cb, 3)
    bus(0, 8'h20, 0); `CHK(r, 32'h0)
    $display("block test done");
    print_verdict();
end
endmodule
bind video_capture_line_channel vcap_checker chk_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
    .hreadyout, .luma_dma_request, .blue_chroma_dma_request, .red_chroma_dma_request);
